/* src/gpf_port.sv */
// gpf_port: sixteen-pin general-purpose flag port with interrupt logic
// assumes: software writes arrive as one op per cycle with a data word;
// pin inputs are synchronous to clk_i only after the internal synchroniser
`timescale 1ns/1ns
`include "gpf_defs.svh"
module gpf_port #(
  parameter int W = `GPF_NPINS,
  parameter int SEL_N = `GPF_SEL_N,
  parameter int SEL_LSB = `GPF_SEL_LSB,
  parameter int SS_PIN = `GPF_SS_PIN
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire gpf_pkg::gpf_op_t op_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] general_purpose_pins_i,
  output logic [W-1:0] general_purpose_pins_o,
  output logic [W-1:0] general_purpose_pins_oe_o,
  input wire logic [SEL_N-1:0] serial_device_select_outputs_en_i,
  input wire logic [SEL_N-1:0] serial_device_select_outputs_i,
  input wire logic serial_slave_select_en_i,
  output logic serial_slave_select_input_o,
  output logic [W-1:0] status_o,
  output logic [W-1:0] dir_o,
  output logic [W-1:0] flag_o,
  output logic [W-1:0] mask_o,
  output logic [W-1:0] sens_o,
  output logic [W-1:0] edge_both_o,
  output logic [W-1:0] pend_o,
  output logic irq_o
);

  // register state
  logic [W-1:0] dir_q;
  logic [W-1:0] dir_d;
  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] mask_d;
  logic [W-1:0] sens_q;
  logic [W-1:0] sens_d;
  logic [W-1:0] both_q;
  logic [W-1:0] both_d;

  // write strobes, decoded once and shared by the flag, mask and interrupt paths
  logic [W-1:0] set_bits;
  logic [W-1:0] clr_bits;
  logic [W-1:0] tog_bits;
  logic [W-1:0] mset_bits;
  logic [W-1:0] mclr_bits;

  // output stage
  logic [W-1:0] pin_out_q;
  logic [W-1:0] pin_out_d;
  logic [W-1:0] pin_oe_q;
  logic [W-1:0] pin_oe_d;
  logic [W-1:0] status_q;
  logic [W-1:0] pend_q;
  logic irq_q;
  logic ss_q;

  // pin claim by the serial port
  logic [W-1:0] sel_claim;
  logic [W-1:0] sel_level;
  logic [W-1:0] pin_sync;

  gpf_evt_if #(.W(W)) ev ();

  // strobe mask: the data word when this op is selected, zero otherwise
  function automatic logic [W-1:0] op_bits(input gpf_pkg::gpf_op_t op,
                                            input gpf_pkg::gpf_op_t want,
                                            input logic [W-1:0] data);
    logic [W-1:0] r;
    r = '0;
    if (op == want) begin
      r = data;
    end
    return r;
  endfunction

  assign set_bits = op_bits(op_i, gpf_pkg::GPF_OP_SET, wdata_i);
  assign clr_bits = op_bits(op_i, gpf_pkg::GPF_OP_CLR, wdata_i);
  assign tog_bits = op_bits(op_i, gpf_pkg::GPF_OP_TOG, wdata_i);
  assign mset_bits = op_bits(op_i, gpf_pkg::GPF_OP_MSET, wdata_i);
  assign mclr_bits = op_bits(op_i, gpf_pkg::GPF_OP_MCLR, wdata_i);

  gpf_sync #(.W(W)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(general_purpose_pins_i),
    .q_o(pin_sync)
  );

  // serial select pin map
  // pins outside the select range are never claimed
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_claim
      if (k >= SEL_LSB && k < SEL_LSB + SEL_N) begin : g_sel
        assign sel_claim[k] = serial_device_select_outputs_en_i[k - SEL_LSB];
        assign sel_level[k] = serial_device_select_outputs_i[k - SEL_LSB];
      end else begin : g_free
        assign sel_claim[k] = 1'b0;
        assign sel_level[k] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    dir_d = dir_q;
    if (op_i == gpf_pkg::GPF_OP_DIR) begin
      dir_d = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_q <= `GPF_RST_DIR;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_comb begin
    flag_d = flag_q;
    flag_d = flag_d | set_bits;
    flag_d = flag_d & ~clr_bits;
    flag_d = flag_d ^ tog_bits;
    if (op_i == gpf_pkg::GPF_OP_VAL) begin
      flag_d = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= `GPF_RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_comb begin
    mask_d = mask_q | mset_bits;
    mask_d = mask_d & ~mclr_bits;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= `GPF_RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_comb begin
    sens_d = sens_q;
    if (op_i == gpf_pkg::GPF_OP_SENS) begin
      sens_d = wdata_i;
    end
  end

  always_comb begin
    both_d = both_q;
    if (op_i == gpf_pkg::GPF_OP_EDGE) begin
      both_d = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sens_q <= `GPF_RST_SENS;
    end else begin
      sens_q <= sens_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      both_q <= `GPF_RST_EDGE;
    end else begin
      both_q <= both_d;
    end
  end

  // interrupt detector hookup
  assign ev.level = pin_sync;
  assign ev.dir = dir_q;
  assign ev.sens = sens_q;
  assign ev.both = both_q;
  // software flag change event
  // next against present flag catches every op kind, not only toggles
  assign ev.sw_evt = flag_d ^ flag_q;
  assign ev.clr = clr_bits;

  gpf_irq #(.W(W)) u_irq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ev(ev.det)
  );

  // unmasked pending view
  // masking only at the request keeps pending visible while disabled
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= ev.pend;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev.pend & mask_q);
    end
  end

  // status sense
  // synchronised pin, so a driven output reads back its own level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= '0;
    end else begin
      status_q <= pin_sync;
    end
  end

  // slave select input
  // idles high so a disabled select never looks asserted
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_q <= 1'b1;
    end else if (serial_slave_select_en_i) begin
      ss_q <= pin_sync[SS_PIN];
    end else begin
      ss_q <= 1'b1;
    end
  end

  // serial port overrides flags
  // registered so pins never glitch while a claim changes
  always_comb begin
    pin_out_d = (flag_d & ~sel_claim) | (sel_level & sel_claim);
  end

  // claimed pins driven, slave select pin never while its input is enabled
  always_comb begin
    pin_oe_d = dir_d | sel_claim;
    if (serial_slave_select_en_i) begin
      pin_oe_d[SS_PIN] = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_oe_q <= '0;
    end else begin
      pin_oe_q <= pin_oe_d;
    end
  end

  assign general_purpose_pins_o = pin_out_q;
  assign general_purpose_pins_oe_o = pin_oe_q;
  assign serial_slave_select_input_o = ss_q;
  assign status_o = status_q;
  assign dir_o = dir_q;
  assign flag_o = flag_q;
  assign mask_o = mask_q;
  assign sens_o = sens_q;
  assign edge_both_o = both_q;
  assign pend_o = pend_q;
  assign irq_o = irq_q;

endmodule // gpf_port

/* src/gpf_defs.svh */
// gpf_defs.svh: constants of the general-purpose flag port
// assumes: included by bare name from the port's design files
//
// Summary of operation
// - sixteen bidirectional pins, one bit each in every control and status word
// - direction word picks input or driven output per pin
// - modify writes touch only pins whose written bit is one
// - set write drives chosen flag values high
// - clear write drives chosen flag values low
// - toggle write inverts chosen flag values
// - four flag controls; the value write loads every flag at once
// - status read returns present sense of every pin
// - mask set write enables chosen pin interrupts only
// - mask clear write disables chosen pin interrupts only
// - enabled input pins request interrupt on their sensitivity condition
// - enabled output pins request interrupt when software changes their flag
// - sensitivity word picks level or edge per pin
// - edge select picks rising only or both edges per pin
// - seven pins become serial selects out, one the serial slave select in
`ifndef GPF_DEFS_SVH
`define GPF_DEFS_SVH

`define GPF_NPINS 16
`define GPF_RST_DIR 16'h0000
`define GPF_RST_FLAG 16'h0000
`define GPF_RST_MASK 16'h0000
`define GPF_RST_SENS 16'h0000
`define GPF_RST_EDGE 16'h0000
`define GPF_SEL_N 7
`define GPF_SEL_LSB 1
`define GPF_SS_PIN 0

`endif

/* src/gpf_pkg.sv */
// gpf_pkg: types of the general-purpose flag port
// assumes: nothing; referenced as gpf_pkg::name
package gpf_pkg;

  typedef enum logic [3:0] {
    GPF_OP_NONE,
    GPF_OP_SET,
    GPF_OP_CLR,
    GPF_OP_TOG,
    GPF_OP_VAL,
    GPF_OP_DIR,
    GPF_OP_MSET,
    GPF_OP_MCLR,
    GPF_OP_SENS,
    GPF_OP_EDGE
  } gpf_op_t;

endpackage

/* src/gpf_evt_if.sv */
// gpf_evt_if: signals between the port core and its interrupt detector
// assumes: both ends run on the same clock
`timescale 1ns/1ns
interface gpf_evt_if #(
  parameter int W = 16
);
  logic [W-1:0] level;
  logic [W-1:0] dir;
  logic [W-1:0] sens;
  logic [W-1:0] both;
  logic [W-1:0] sw_evt;
  logic [W-1:0] clr;
  logic [W-1:0] pend;

  modport core (output level, output dir, output sens, output both, output sw_evt, output clr, input pend);
  modport det (input level, input dir, input sens, input both, input sw_evt, input clr, output pend);
endinterface

/* src/gpf_sync.sv */
// gpf_sync: two-flop synchroniser for a vector of pin inputs
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ns
module gpf_sync #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // gpf_sync

/* src/gpf_irq.sv */
// gpf_irq: per-pin interrupt condition detection and edge latching
// assumes: level inputs already synchronised; clr is a one-cycle pulse per bit
`timescale 1ns/1ns
module gpf_irq #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  gpf_evt_if.det ev
);
  logic [W-1:0] prev_q;
  logic [W-1:0] latch_q;
  logic [W-1:0] hw_edge;
  logic [W-1:0] level_hit;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= ev.level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      assign hw_edge[i] = ~ev.dir[i] & ev.sens[i] &
                          (ev.both[i] ? (ev.level[i] ^ prev_q[i]) : (ev.level[i] & ~prev_q[i]));
      assign level_hit[i] = ~ev.dir[i] & ~ev.sens[i] & ev.level[i];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_q <= '0;
    end else begin
      latch_q <= (latch_q & ~ev.clr) | hw_edge | (ev.dir & ev.sw_evt);
    end
  end

  assign ev.pend = latch_q | level_hit;
endmodule // gpf_irq

/* tb/gpf_port_monitor.sv */
// gpf_port_monitor: port-level properties of the flag port
// assumes: bound to gpf_port, one clock, async active-low reset
`timescale 1ns/1ns
module gpf_port_monitor #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire gpf_pkg::gpf_op_t op_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] general_purpose_pins_i,
  input wire logic [W-1:0] status_o,
  input wire logic [W-1:0] dir_o,
  input wire logic [W-1:0] flag_o,
  input wire logic [W-1:0] mask_o,
  input wire logic irq_o
);
  logic [1:0] up_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // the sync pipe still holds reset values for three edges after release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  a_set_flag_high: assert property (
    op_i == gpf_pkg::GPF_OP_SET |=> flag_o == ($past(flag_o) | $past(wdata_i))) else $error("set wrong");
  a_clr_flag_low: assert property (
    op_i == gpf_pkg::GPF_OP_CLR |=> flag_o == ($past(flag_o) & ~$past(wdata_i))) else $error("clear wrong");
  a_tog_flag_inv: assert property (
    op_i == gpf_pkg::GPF_OP_TOG |-> ##1 flag_o == ($past(flag_o) ^ $past(wdata_i))) else $error("toggle wrong");
  a_val_loads_all: assert property (
    op_i == gpf_pkg::GPF_OP_VAL |=> flag_o == $past(wdata_i)) else $error("value load wrong");
  a_mask_set_only: assert property (
    op_i == gpf_pkg::GPF_OP_MSET |=> mask_o == ($past(mask_o) | $past(wdata_i))) else $error("mask set wrong");
  a_mask_clr_only: assert property (
    op_i == gpf_pkg::GPF_OP_MCLR |-> ##1 mask_o == ($past(mask_o) & ~$past(wdata_i))) else $error("mask clr wrong");
  a_dir_load_word: assert property (
    op_i == gpf_pkg::GPF_OP_DIR |=> dir_o == $past(wdata_i)) else $error("direction wrong");
  a_status_three_late: assert property (
    up_q == 2'h3 |-> status_o == $past(general_purpose_pins_i, 3)) else $error("status not synced");
  c_irq_rise: cover property ($rose(irq_o));
  c_toggle: cover property (op_i == gpf_pkg::GPF_OP_TOG);
  c_mask_drop: cover property (op_i == gpf_pkg::GPF_OP_MCLR ##2 !irq_o);
endmodule // gpf_port_monitor
bind gpf_port gpf_port_monitor #(.W(W)) u_mon (.clk_i, .arst_n_i, .op_i, .wdata_i, .general_purpose_pins_i,
  .status_o, .dir_o, .flag_o, .mask_o, .irq_o);

/* tb/gpf_board.sv */
// gpf_board: board side of the sixteen flag pins
// assumes: the port drives a pin only while its enable is high
`timescale 1ns/1ns
module gpf_board (
  input wire logic [15:0] drive_i,
  input wire logic [15:0] oe_i,
  input wire logic [15:0] ext_i,
  output logic [15:0] pin_o
);
  // driven pins read back
  // undriven pins show the board level; no pull resistors are assumed
  assign pin_o = (drive_i & oe_i) | (ext_i & ~oe_i);
endmodule // gpf_board

/* tb/testbench.sv */
// testbench: random and directed stimulus for the flag port
// assumes: gpf_board resolves each pin from the port's enables
`timescale 1ns/1ns
module testbench;
  logic clk_i, arst_n_i, serial_slave_select_en_i, serial_slave_select_input_o, irq_o;
  gpf_pkg::gpf_op_t op_i;
  logic [15:0] wdata_i, general_purpose_pins_i, general_purpose_pins_o, general_purpose_pins_oe_o, ext, v;
  logic [15:0] status_o, dir_o, flag_o, mask_o, sens_o, edge_both_o, pend_o, m_flag, m_dir, m_mask, m_sens, m_eb;
  logic [6:0] serial_device_select_outputs_en_i, serial_device_select_outputs_i;
  int seed = 32'h99b2;
  int bad_count, comparisons;
  gpf_port dut (.clk_i, .arst_n_i, .op_i, .wdata_i, .general_purpose_pins_i, .general_purpose_pins_o,
    .general_purpose_pins_oe_o, .serial_device_select_outputs_en_i, .serial_device_select_outputs_i,
    .serial_slave_select_en_i, .serial_slave_select_input_o, .status_o, .dir_o, .flag_o, .mask_o,
    .sens_o, .edge_both_o, .pend_o, .irq_o);
  gpf_board board (.drive_i(general_purpose_pins_o), .oe_i(general_purpose_pins_oe_o), .ext_i(ext),
    .pin_o(general_purpose_pins_i));
  function automatic logic [15:0] fx(input gpf_pkg::gpf_op_t o, input logic [15:0] q, input logic [15:0] d);
    case (o)
      gpf_pkg::GPF_OP_SET, gpf_pkg::GPF_OP_MSET: fx = q | d;
      gpf_pkg::GPF_OP_CLR, gpf_pkg::GPF_OP_MCLR: fx = q & ~d;
      gpf_pkg::GPF_OP_TOG: fx = q ^ d;
      default: fx = d;
    endcase
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one op per call; the model follows what the op must do
  task automatic wr(input gpf_pkg::gpf_op_t o, input logic [15:0] d);
    @(posedge clk_i);
    op_i <= o;
    wdata_i <= d;
    @(posedge clk_i);
    op_i <= gpf_pkg::GPF_OP_NONE;
    case (o)
      gpf_pkg::GPF_OP_DIR: m_dir = d;
      gpf_pkg::GPF_OP_MSET, gpf_pkg::GPF_OP_MCLR: m_mask = fx(o, m_mask, d);
      gpf_pkg::GPF_OP_SENS: m_sens = d;
      gpf_pkg::GPF_OP_EDGE: m_eb = d;
      default: m_flag = fx(o, m_flag, d);
    endcase
    #1;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pin(input logic [15:0] d);
    @(posedge clk_i);
    ext <= d;
    wt(5);
  endtask
  task automatic regs;
    check("flag", flag_o, m_flag);
    check("pins", general_purpose_pins_o, m_flag);
    check("oe", general_purpose_pins_oe_o, m_dir);
    check("dir", dir_o, m_dir);
    check("mask", mask_o, m_mask);
    check("sens", sens_o, m_sens);
    check("edges", edge_both_o, m_eb);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {arst_n_i, serial_slave_select_en_i, serial_device_select_outputs_en_i, serial_device_select_outputs_i} = '0;
    {wdata_i, ext, m_flag, m_dir, m_mask, m_sens, m_eb} = '0;
    op_i = gpf_pkg::GPF_OP_NONE;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    regs;
    check("ss", serial_slave_select_input_o, 1'b1);
    wr(gpf_pkg::GPF_OP_VAL, 16'hffff);
    wr(gpf_pkg::GPF_OP_CLR, 16'h0000);
    regs;
    for (int i = 0; i < 40; i++) begin
      wr(gpf_pkg::gpf_op_t'(4'h1 + 4'($unsigned($random(seed)) % 9)), 16'($random(seed)));
      regs;
    end
    wr(gpf_pkg::GPF_OP_DIR, 16'h0000);
    wr(gpf_pkg::GPF_OP_SENS, 16'hffff);
    wr(gpf_pkg::GPF_OP_EDGE, 16'h0000);
    wr(gpf_pkg::GPF_OP_MSET, 16'hffff);
    wt(5);
    wr(gpf_pkg::GPF_OP_CLR, 16'hffff);
    pin(16'h0020);
    check("pend", pend_o, 16'h0020);
    check("irq", irq_o, 1'b1);
    wr(gpf_pkg::GPF_OP_CLR, 16'h0020);
    pin(16'h0000);
    check("pend", pend_o, 16'h0000);
    wr(gpf_pkg::GPF_OP_EDGE, 16'hffff);
    pin(16'h0020);
    wr(gpf_pkg::GPF_OP_CLR, 16'h0020);
    pin(16'h0000);
    check("pend", pend_o, 16'h0020);
    wr(gpf_pkg::GPF_OP_MCLR, 16'hffdf);
    wt(2);
    check("irq", irq_o, 1'b1);
    wr(gpf_pkg::GPF_OP_MCLR, 16'h0020);
    wt(2);
    check("irq", irq_o, 1'b0);
    wr(gpf_pkg::GPF_OP_SENS, 16'h0000);
    wr(gpf_pkg::GPF_OP_CLR, 16'hffff);
    v = 16'($random(seed));
    pin(v);
    check("status", status_o, v);
    check("pend", pend_o, v);
    pin(16'h0000);
    check("pend", pend_o, 16'h0000);
    wr(gpf_pkg::GPF_OP_DIR, 16'h0001);
    wr(gpf_pkg::GPF_OP_MSET, 16'h0001);
    wt(3);
    check("irq", irq_o, 1'b0);
    wr(gpf_pkg::GPF_OP_SET, 16'h0001);
    wt(3);
    check("irq", irq_o, 1'b1);
    check("bus", general_purpose_pins_i, 16'h0001);
    wr(gpf_pkg::GPF_OP_DIR, 16'hffff);
    @(posedge clk_i);
    serial_device_select_outputs_en_i <= 7'h7f;
    serial_device_select_outputs_i <= 7'($random(seed));
    serial_slave_select_en_i <= 1'b1;
    pin(16'h0001);
    check("sel", general_purpose_pins_o[7:1], serial_device_select_outputs_i);
    check("ss oe", general_purpose_pins_oe_o[0], 1'b0);
    check("ss", serial_slave_select_input_o, 1'b1);
    pin(16'h0000);
    check("ss", serial_slave_select_input_o, 1'b0);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    {serial_slave_select_en_i, serial_device_select_outputs_en_i} <= '0;
    {m_flag, m_dir, m_mask, m_sens, m_eb} = '0;
    wt(2);
    regs;
    check("pend", pend_o, 16'h0000);
    check("irq", irq_o, 1'b0);
    check("ss", serial_slave_select_input_o, 1'b1);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    wr(gpf_pkg::GPF_OP_VAL, v);
    regs;
    tally_and_finish;
  end
endmodule // testbench
